// ===== hdl/ufs_channel_regs.v
// One UART channel's register file: fill level, trigger, flow characters,
// flow status and the reset state of the channel registers and pins.
// Assumes an 8-bit register port on sys_clk; modem inputs are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "ufs_defs.vh"

// How it works
// - The receive fill count is a read-only 0..64 count of characters held; writes leave it alone.
// - Software writes an 8-bit receive trigger threshold from 0 to 64.
// - The receive interrupt asserts once the fill count reaches the trigger threshold.
// - Four write-only registers hold the first and second stop and resume characters.
// - The flow character status reads zero whenever software flow control is off.
// - Status bit 3 shows the last sent flow character was a resume.
// - Status bit 2 shows the last sent flow character was a stop.
// - Status bit 1 shows the last received flow character was a resume.
// - Status bit 0 shows the last received flow character was a stop; bits 7..4 read zero.
// - Reading the flow character status clears its indicator bits.
// - Reset sets divisor low 01, interrupt source 01, line state 60, scratch ff and the rest zero.
// - Reset clears modem state bits 3..0 while bits 7..4 follow the modem inputs.
// - Reset drives transmit, RTS# and DTR# high and infrared and serial memory pins low.
// - Software flow control is off when the four flow select bits are all zero.
module ufs_channel_regs (
    input wire sys_clk,
    input wire rst,
    input wire [4:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire rx_push,
    input wire rx_pop,
    input wire tx_resume_sent,
    input wire tx_stop_sent,
    input wire rx_resume_seen,
    input wire rx_stop_seen,
    input wire [3:0] modem_in,
    input wire serial_tx_in,
    input wire infrared_tx_in,
    input wire serial_memory_clock_in,
    input wire serial_memory_select_in,
    input wire serial_memory_data_in,
    output reg rx_irq,
    output reg [7:0] stop_char_first,
    output reg [7:0] stop_char_second,
    output reg [7:0] resume_char_first,
    output reg [7:0] resume_char_second,
    output reg [3:0] flow_select,
    output reg serial_tx_out,
    output reg rts_n,
    output reg dtr_n,
    output reg infrared_transmit_out,
    output reg serial_memory_clock,
    output reg serial_memory_select,
    output reg serial_memory_data_out
);

    reg [7:0] divisor_low;
    reg [7:0] divisor_high_byte;
    reg [7:0] divisor_fraction;
    reg [7:0] interrupt_enables;
    reg [7:0] fifo_control;
    reg [7:0] interrupt_source;
    reg [7:0] line_control;
    reg [7:0] modem_control;
    reg [7:0] line_state;
    reg [3:0] modem_delta;
    reg [7:0] scratch_byte;
    reg [7:0] feature_control;
    reg [7:0] enhanced_feature_select;
    reg [7:0] receive_trigger_threshold;
    reg [3:0] modem_meta;
    reg [3:0] modem_sync;
    reg [3:0] modem_prev;
    reg [7:0] next_rdata;
    wire [7:0] receive_fill_count;
    wire [7:0] flow_char_status;
    wire at_trigger;
    wire flow_enabled;
    wire wr_hit;
    wire rd_flow;
    wire rd_modem;
    wire rx_irq_pending;

    assign wr_hit = reg_wr;
    assign rd_flow = reg_rd && (reg_addr == `UFS_A_FLOW_STAT);
    assign rd_modem = reg_rd && (reg_addr == `UFS_A_MODEM_STATE);
    assign flow_enabled = (enhanced_feature_select[`UFS_FLOW_SEL_HI:`UFS_FLOW_SEL_LO] != 4'h0);
    assign rx_irq_pending = at_trigger && interrupt_enables[`UFS_IE_RX];

    ufs_fill_level u_fill (
        .sys_clk(sys_clk),
        .rst(rst),
        .rx_push(rx_push),
        .rx_pop(rx_pop),
        .trigger(receive_trigger_threshold),
        .count(receive_fill_count),
        .at_trigger(at_trigger)
    );

    ufs_flow_status u_flow (
        .sys_clk(sys_clk),
        .rst(rst),
        .flow_enabled(flow_enabled),
        .tx_resume_sent(tx_resume_sent),
        .tx_stop_sent(tx_stop_sent),
        .rx_resume_seen(rx_resume_seen),
        .rx_stop_seen(rx_stop_seen),
        .read_clear(rd_flow),
        .status(flow_char_status)
    );

    // Modem inputs cross in through two flops, then a per-bit change detector
    genvar gi;
    generate
        for (gi = 0; gi < `UFS_MODEM_BITS; gi = gi + 1) begin : g_modem
            always @(posedge sys_clk) begin
                modem_meta[gi] <= modem_in[gi];
                modem_sync[gi] <= modem_meta[gi];
                // Tracks the synced level in reset too, so no false change follows it
                modem_prev[gi] <= modem_sync[gi];
            end
            // Change sets a delta bit; set beats the read clear
            always @(posedge sys_clk) begin
                if (rst) begin
                    modem_delta[gi] <= 1'b0;
                end else begin
                    modem_delta[gi] <= (modem_delta[gi] && !rd_modem) || (modem_sync[gi] != modem_prev[gi]);
                end
            end
        end
    endgenerate

    // Writable registers
    always @(posedge sys_clk) begin
        if (rst) begin
            divisor_low <= `UFS_RST_DIV_LOW;
            divisor_high_byte <= `UFS_RST_ZERO;
            divisor_fraction <= `UFS_RST_ZERO;
            interrupt_enables <= `UFS_RST_ZERO;
            fifo_control <= `UFS_RST_ZERO;
            line_control <= `UFS_RST_ZERO;
            modem_control <= `UFS_RST_ZERO;
            scratch_byte <= `UFS_RST_SCRATCH;
            feature_control <= `UFS_RST_ZERO;
            enhanced_feature_select <= `UFS_RST_ZERO;
            receive_trigger_threshold <= `UFS_RST_ZERO;
            stop_char_first <= `UFS_RST_ZERO;
            stop_char_second <= `UFS_RST_ZERO;
            resume_char_first <= `UFS_RST_ZERO;
            resume_char_second <= `UFS_RST_ZERO;
        end else if (wr_hit) begin
            case (reg_addr)
                `UFS_A_DIV_LOW: begin
                    divisor_low <= reg_wdata;
                end
                `UFS_A_DIV_HIGH: begin
                    divisor_high_byte <= reg_wdata;
                end
                `UFS_A_DIV_FRAC: begin
                    divisor_fraction <= reg_wdata;
                end
                `UFS_A_INT_EN: begin
                    interrupt_enables <= reg_wdata;
                end
                `UFS_A_FIFO_CTL: begin
                    fifo_control <= reg_wdata;
                end
                `UFS_A_LINE_CTL: begin
                    line_control <= reg_wdata;
                end
                `UFS_A_MODEM_CTL: begin
                    modem_control <= reg_wdata;
                end
                `UFS_A_SCRATCH: begin
                    scratch_byte <= reg_wdata;
                end
                `UFS_A_FEATURE_CTL: begin
                    feature_control <= reg_wdata;
                end
                `UFS_A_ENH_SEL: begin
                    enhanced_feature_select <= reg_wdata;
                end
                `UFS_A_RX_TRIG: begin
                    receive_trigger_threshold <= reg_wdata;
                end
                `UFS_A_STOP1: begin
                    stop_char_first <= reg_wdata;
                end
                `UFS_A_STOP2: begin
                    stop_char_second <= reg_wdata;
                end
                `UFS_A_RESUME1: begin
                    resume_char_first <= reg_wdata;
                end
                `UFS_A_RESUME2: begin
                    resume_char_second <= reg_wdata;
                end
                default: ;
            endcase
        end
    end

    // Status registers driven by the channel
    always @(posedge sys_clk) begin
        if (rst) begin
            interrupt_source <= `UFS_RST_INT_SRC;
            line_state <= `UFS_RST_LINE_STATE;
            rx_irq <= 1'b0;
        end else begin
            interrupt_source <= rx_irq_pending ? `UFS_ISRC_RX_TRIG : `UFS_ISRC_NONE;
            line_state <= `UFS_RST_LINE_STATE;
            line_state[`UFS_LS_READY] <= (receive_fill_count != `UFS_RST_ZERO);
            rx_irq <= rx_irq_pending;
        end
    end

    // Read mux; write-only and unmapped indexes read zero
    always @* begin
        next_rdata = `UFS_RST_ZERO;
        case (reg_addr)
            `UFS_A_DIV_LOW: begin
                next_rdata = divisor_low;
            end
            `UFS_A_DIV_HIGH: begin
                next_rdata = divisor_high_byte;
            end
            `UFS_A_DIV_FRAC: begin
                next_rdata = divisor_fraction;
            end
            `UFS_A_INT_EN: begin
                next_rdata = interrupt_enables;
            end
            `UFS_A_FIFO_CTL: begin
                next_rdata = fifo_control;
            end
            `UFS_A_INT_SRC: begin
                next_rdata = interrupt_source;
            end
            `UFS_A_LINE_CTL: begin
                next_rdata = line_control;
            end
            `UFS_A_MODEM_CTL: begin
                next_rdata = modem_control;
            end
            `UFS_A_LINE_STATE: begin
                next_rdata = line_state;
            end
            `UFS_A_MODEM_STATE: begin
                next_rdata = {modem_sync, modem_delta};
            end
            `UFS_A_SCRATCH: begin
                next_rdata = scratch_byte;
            end
            `UFS_A_FEATURE_CTL: begin
                next_rdata = feature_control;
            end
            `UFS_A_ENH_SEL: begin
                next_rdata = enhanced_feature_select;
            end
            `UFS_A_RX_FILL: begin
                next_rdata = receive_fill_count;
            end
            `UFS_A_FLOW_STAT: begin
                next_rdata = flow_char_status;
            end
            default: begin
                next_rdata = `UFS_RST_ZERO;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= `UFS_RST_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // Pins and flow selection
    always @(posedge sys_clk) begin
        if (rst) begin
            serial_tx_out <= 1'b1;
            rts_n <= 1'b1;
            dtr_n <= 1'b1;
            infrared_transmit_out <= 1'b0;
            serial_memory_clock <= 1'b0;
            serial_memory_select <= 1'b0;
            serial_memory_data_out <= 1'b0;
            flow_select <= 4'h0;
        end else begin
            serial_tx_out <= serial_tx_in;
            rts_n <= ~modem_control[`UFS_MC_RTS];
            dtr_n <= ~modem_control[`UFS_MC_DTR];
            infrared_transmit_out <= infrared_tx_in;
            serial_memory_clock <= serial_memory_clock_in;
            serial_memory_select <= serial_memory_select_in;
            serial_memory_data_out <= serial_memory_data_in;
            flow_select <= enhanced_feature_select[`UFS_FLOW_SEL_HI:`UFS_FLOW_SEL_LO];
        end
    end

endmodule // ufs_channel_regs
`default_nettype wire

// ===== hdl/ufs_defs.vh
// Constants for the per-channel fill-level, flow-character and reset-state logic.
// Assumes an 8-bit register port with a 5-bit register index.
`ifndef UFS_DEFS_VH
`define UFS_DEFS_VH

// Register indexes
`define UFS_A_DIV_LOW 5'h00
`define UFS_A_DIV_HIGH 5'h01
`define UFS_A_DIV_FRAC 5'h02
`define UFS_A_INT_EN 5'h03
`define UFS_A_FIFO_CTL 5'h04
`define UFS_A_INT_SRC 5'h05
`define UFS_A_LINE_CTL 5'h06
`define UFS_A_MODEM_CTL 5'h07
`define UFS_A_LINE_STATE 5'h08
`define UFS_A_MODEM_STATE 5'h09
`define UFS_A_SCRATCH 5'h0a
`define UFS_A_FEATURE_CTL 5'h0b
`define UFS_A_ENH_SEL 5'h0c
`define UFS_A_RX_FILL 5'h0d
`define UFS_A_RX_TRIG 5'h0e
`define UFS_A_STOP1 5'h0f
`define UFS_A_STOP2 5'h10
`define UFS_A_RESUME1 5'h11
`define UFS_A_RESUME2 5'h12
`define UFS_A_FLOW_STAT 5'h13

// Reset values
`define UFS_RST_ZERO 8'h00
`define UFS_RST_DIV_LOW 8'h01
`define UFS_RST_INT_SRC 8'h01
`define UFS_RST_LINE_STATE 8'h60
`define UFS_RST_SCRATCH 8'hff

// Interrupt source codes
`define UFS_ISRC_NONE 8'h01
`define UFS_ISRC_RX_TRIG 8'h04

// Fill counter
`define UFS_FIFO_DEPTH 8'h40
`define UFS_CNT_ONE 8'h01

// Modem input lines
`define UFS_MODEM_BITS 4

// Field positions
`define UFS_IE_RX 0
`define UFS_MC_DTR 0
`define UFS_MC_RTS 1
`define UFS_LS_READY 0
`define UFS_FLOW_SEL_HI 3
`define UFS_FLOW_SEL_LO 0
`define UFS_FS_TX_RESUME 3
`define UFS_FS_TX_STOP 2
`define UFS_FS_RX_RESUME 1
`define UFS_FS_RX_STOP 0

`endif

// ===== hdl/ufs_fill_level.v
// Receive FIFO fill counter and trigger-level interrupt.
// Assumes push and pop are one-cycle pulses from same-clock FIFO logic.
`timescale 1ns/1ps
`default_nettype none
`include "ufs_defs.vh"

module ufs_fill_level (
    input wire sys_clk,
    input wire rst,
    input wire rx_push,
    input wire rx_pop,
    input wire [7:0] trigger,
    output reg [7:0] count,
    output reg at_trigger
);

    reg [7:0] next_count;
    wire do_push;
    wire do_pop;

    // Saturate at empty and full
    assign do_push = rx_push && (count != `UFS_FIFO_DEPTH);
    assign do_pop = rx_pop && (count != `UFS_RST_ZERO);

    always @* begin
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = count + `UFS_CNT_ONE;
        end else if (do_pop && !do_push) begin
            next_count = count - `UFS_CNT_ONE;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            count <= `UFS_RST_ZERO;
            at_trigger <= 1'b0;
        end else begin
            count <= next_count;
            at_trigger <= (next_count >= trigger);
        end
    end

endmodule // ufs_fill_level
`default_nettype wire

// ===== hdl/ufs_flow_status.v
// Last sent / last received flow-control character indicators.
// Assumes event inputs are one-cycle pulses from same-clock flow logic.
`timescale 1ns/1ps
`default_nettype none
`include "ufs_defs.vh"

module ufs_flow_status (
    input wire sys_clk,
    input wire rst,
    input wire flow_enabled,
    input wire tx_resume_sent,
    input wire tx_stop_sent,
    input wire rx_resume_seen,
    input wire rx_stop_seen,
    input wire read_clear,
    output reg [7:0] status
);

    reg [7:0] next_status;

    always @* begin
        next_status = status;
        if (read_clear) begin
            next_status = `UFS_RST_ZERO;
        end
        // Latest event per direction wins; set beats read clear
        if (tx_resume_sent) begin
            next_status[`UFS_FS_TX_RESUME] = 1'b1;
            next_status[`UFS_FS_TX_STOP] = 1'b0;
        end else if (tx_stop_sent) begin
            next_status[`UFS_FS_TX_STOP] = 1'b1;
            next_status[`UFS_FS_TX_RESUME] = 1'b0;
        end
        if (rx_resume_seen) begin
            next_status[`UFS_FS_RX_RESUME] = 1'b1;
            next_status[`UFS_FS_RX_STOP] = 1'b0;
        end else if (rx_stop_seen) begin
            next_status[`UFS_FS_RX_STOP] = 1'b1;
            next_status[`UFS_FS_RX_RESUME] = 1'b0;
        end
        next_status[7:4] = 4'h0;
        if (!flow_enabled) begin
            next_status = `UFS_RST_ZERO;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            status <= `UFS_RST_ZERO;
        end else begin
            status <= next_status;
        end
    end

endmodule // ufs_flow_status
`default_nettype wire

// ===== dv/ufs_remote.sv
// Remote serial device model: each item sent is data or a flow character.
// Assumes send and kind come from the bench on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ufs_remote (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic send,
    input wire logic [1:0] kind,
    output logic rx_push,
    output logic rx_stop_seen,
    output logic rx_resume_seen
);
    // One pulse per item, quiet in reset
    always @(posedge sys_clk) begin
        rx_push <= !rst && send && kind == 2'h0;
        rx_stop_seen <= !rst && send && kind == 2'h1;
        rx_resume_seen <= !rst && send && kind == 2'h2;
    end
endmodule // ufs_remote
`default_nettype wire

// ===== dv/ufs_chk.sv
// Assertions on the channel register block ports.
// Assumes one sys_clk domain and a synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module ufs_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic rx_push,
    input wire logic tx_resume_sent,
    input wire logic tx_stop_sent,
    input wire logic rx_resume_seen,
    input wire logic rx_stop_seen,
    input wire logic rx_irq,
    input wire logic [7:0] stop_char_first,
    input wire logic [3:0] flow_select,
    input wire logic serial_tx_out,
    input wire logic rts_n,
    input wire logic dtr_n,
    input wire logic infrared_transmit_out,
    input wire logic serial_memory_clock,
    input wire logic serial_memory_select,
    input wire logic serial_memory_data_out
);
    wire rd_st = reg_rd && reg_addr == 5'h13;
    wire fc_on = flow_select != 4'h0;
    wire tx_q = !tx_resume_sent && !tx_stop_sent;
    wire rx_q = !rx_resume_seen && !rx_stop_seen;
    wire [6:0] pins = {serial_tx_out, rts_n, dtr_n, infrared_transmit_out, serial_memory_clock,
        serial_memory_select, serial_memory_data_out};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_rst; disable iff (1'b0) rst |=> pins == 7'h70 && !fc_on && stop_char_first == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_irq; $rose(rx_irq) |-> $past(rx_push, 2) || $past(reg_wr, 2); endproperty
    a_irq: assert property (p_irq) else $error("irq rose without cause");
    property p_stop1; reg_wr && reg_addr == 5'h0f |=> stop_char_first == $past(reg_wdata); endproperty
    a_stop1: assert property (p_stop1) else $error("stop char not stored");
    property p_off; rd_st && !fc_on |=> fc_on || reg_rdata == 8'h00; endproperty
    a_off: assert property (p_off) else $error("status not zero when off");
    property p_resv; rd_st |=> reg_rdata[7:4] == 4'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    property p_clr;
        rd_st && tx_q && rx_q ##1 !reg_rd && tx_q && rx_q ##1 rd_st |=> reg_rdata == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("status not cleared by read");
    property p_txr;
        tx_resume_sent && fc_on ##1 tx_q && fc_on && !rd_st ##1 tx_q && fc_on && rd_st
            |=> !fc_on || reg_rdata[3:2] == 2'b10;
    endproperty
    a_txr: assert property (p_txr) else $error("sent resume not shown");
    property p_txs;
        tx_stop_sent && !tx_resume_sent && fc_on ##1 tx_q && fc_on && !rd_st ##1 tx_q && fc_on && rd_st
            |=> !fc_on || reg_rdata[3:2] == 2'b01;
    endproperty
    a_txs: assert property (p_txs) else $error("sent stop not shown");
    property p_rxr; rx_resume_seen && fc_on ##1 rx_q && fc_on && rd_st |=> !fc_on || reg_rdata[1:0] == 2'b10;
    endproperty
    a_rxr: assert property (p_rxr) else $error("seen resume not shown");
    property p_rxs;
        rx_stop_seen && !rx_resume_seen && fc_on ##1 rx_q && fc_on && rd_st |=> !fc_on || reg_rdata[1:0] == 2'b01;
    endproperty
    a_rxs: assert property (p_rxs) else $error("seen stop not shown");
    c_irq: cover property (rx_push ##2 rx_irq);
    c_rd_on: cover property (rd_st && fc_on);
    c_rx_rd: cover property (rx_stop_seen ##1 rd_st);
endmodule // ufs_chk
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the channel register block.
// Assumes the checker and remote device model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_pop = 0, send = 0;
    logic tx_resume_sent = 0, tx_stop_sent = 0, serial_tx_in = 0, infrared_tx_in = 1;
    logic serial_memory_clock_in = 1, serial_memory_select_in = 1, serial_memory_data_in = 1;
    logic [1:0] kind = 0;
    logic [3:0] modem_in = 4'ha;
    logic [4:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0;
    logic rx_push, rx_resume_seen, rx_stop_seen, rx_irq, serial_tx_out, rts_n, dtr_n;
    logic infrared_transmit_out, serial_memory_clock, serial_memory_select, serial_memory_data_out;
    logic [3:0] flow_select;
    logic [7:0] reg_rdata, stop_char_first, stop_char_second, resume_char_first, resume_char_second;
    int miscompares = 0, n_tests = 0, cyc = 0, i;
    // Register index beside its value after reset
    logic [12:0] rows [20] = '{13'h0001, 13'h0100, 13'h0200, 13'h0300, 13'h0400, 13'h0501, 13'h0600,
        13'h0700, 13'h0860, 13'h0aff, 13'h0b00, 13'h0c00, 13'h0d00, 13'h0e00, 13'h0f00, 13'h1000,
        13'h1100, 13'h1200, 13'h1300, 13'h1f00};
    always #5 sys_clk = ~sys_clk;
    ufs_channel_regs DUT (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .rx_push, .rx_pop,
        .tx_resume_sent, .tx_stop_sent, .rx_resume_seen, .rx_stop_seen, .modem_in, .serial_tx_in, .infrared_tx_in,
        .serial_memory_clock_in, .serial_memory_select_in, .serial_memory_data_in, .rx_irq, .stop_char_first,
        .stop_char_second, .resume_char_first, .resume_char_second, .flow_select, .serial_tx_out, .rts_n, .dtr_n,
        .infrared_transmit_out, .serial_memory_clock, .serial_memory_select, .serial_memory_data_out);
    ufs_remote REMOTE (.sys_clk, .rst, .send, .kind, .rx_push, .rx_stop_seen, .rx_resume_seen);
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task print_verdict;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge sys_clk);
        reg_wr <= 0;
    endtask
    // Read, leaving reg_rdata settled
    task rd(input logic [4:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge sys_clk);
        reg_rd <= 0;
        #1;
    endtask
    task ev(input logic [2:0] v);
        @(posedge sys_clk);
        {rx_pop, tx_resume_sent, tx_stop_sent} <= v;
        @(posedge sys_clk);
        {rx_pop, tx_resume_sent, tx_stop_sent} <= 3'h0;
    endtask
    task snd(input logic [1:0] k);
        @(posedge sys_clk);
        send <= 1;
        kind <= k;
        @(posedge sys_clk);
        send <= 0;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            print_verdict;
        end
    end
    initial begin
        repeat (19) @(posedge sys_clk);
        #1 chk(32'({serial_tx_out, rts_n, dtr_n, infrared_transmit_out, serial_memory_clock, serial_memory_select,
            serial_memory_data_out}), 32'h70);
        @(posedge sys_clk);
        rst <= 0;
        for (i = 0; i < 20; i++) begin
            rd(rows[i][12:8]);
            chk(32'(reg_rdata), 32'(rows[i][7:0]));
        end
        chk(32'({serial_tx_out, rts_n, dtr_n, infrared_transmit_out, serial_memory_clock, serial_memory_select,
            serial_memory_data_out}), 32'h3f);
        rd(5'h09);
        chk(32'(reg_rdata), 32'ha0);
        // Modem input change sets delta bits, a read clears them
        @(posedge sys_clk);
        modem_in <= 4'h5;
        repeat (3) @(posedge sys_clk);
        rd(5'h09);
        chk(32'(reg_rdata), 32'h5f);
        rd(5'h09);
        chk(32'(reg_rdata), 32'h50);
        for (i = 0; i < 4; i++) wr(5'(15 + i), 8'(17 * (i + 1)));
        #1 chk({stop_char_first, stop_char_second, resume_char_first, resume_char_second}, 32'h11223344);
        wr(5'h07, 8'h03);
        @(posedge sys_clk);
        #1 chk(32'({rts_n, dtr_n}), 32'h0);
        wr(5'h0e, 8'h03);
        wr(5'h03, 8'h01);
        repeat (2) snd(2'h0);
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(rx_irq), 32'h0);
        snd(2'h0);
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(rx_irq), 32'h1);
        rd(5'h05);
        chk(32'(reg_rdata), 32'h04);
        rd(5'h08);
        chk(32'(reg_rdata), 32'h61);
        wr(5'h0d, 8'h00);
        rd(5'h0d);
        chk(32'(reg_rdata), 32'h03);
        repeat (3) ev(3'b100);
        repeat (65) snd(2'h0);
        rd(5'h0d);
        chk(32'(reg_rdata), 32'h40);
        snd(2'h1);
        rd(5'h13);
        chk(32'(reg_rdata), 32'h00);
        wr(5'h0c, 8'h0f);
        ev(3'b001);
        #1 chk(32'(flow_select), 32'hf);
        rd(5'h13);
        chk(32'(reg_rdata), 32'h04);
        rd(5'h13);
        chk(32'(reg_rdata), 32'h00);
        // Event and read clear in one cycle: the set wins
        @(posedge sys_clk);
        reg_addr <= 5'h13;
        reg_rd <= 1;
        tx_stop_sent <= 1;
        @(posedge sys_clk);
        reg_rd <= 0;
        tx_stop_sent <= 0;
        #1 chk(32'(reg_rdata), 32'h00);
        rd(5'h13);
        chk(32'(reg_rdata), 32'h04);
        ev(3'b001);
        ev(3'b010);
        rd(5'h13);
        chk(32'(reg_rdata), 32'h08);
        snd(2'h1);
        rd(5'h13);
        chk(32'(reg_rdata), 32'h01);
        snd(2'h1);
        snd(2'h2);
        rd(5'h13);
        chk(32'(reg_rdata), 32'h02);
        ev(3'b011);
        snd(2'h2);
        wr(5'h0c, 8'h00);
        rd(5'h13);
        chk(32'(reg_rdata), 32'h00);
        // Reset again in mid-run
        @(posedge sys_clk);
        rst <= 1;
        repeat (3) @(posedge sys_clk);
        #1 chk({stop_char_first, stop_char_second, resume_char_first, resume_char_second}, 32'h0);
        chk(32'({serial_tx_out, rts_n, dtr_n, infrared_transmit_out, serial_memory_clock, serial_memory_select,
            serial_memory_data_out}), 32'h70);
        @(posedge sys_clk);
        rst <= 0;
        rd(5'h0a);
        chk(32'(reg_rdata), 32'hff);
        rd(5'h09);
        chk(32'(reg_rdata), 32'h50);
        print_verdict;
    end
endmodule // tb
bind ufs_channel_regs ufs_chk u_chk (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .rx_push,
    .tx_resume_sent, .tx_stop_sent, .rx_resume_seen, .rx_stop_seen, .rx_irq, .stop_char_first, .flow_select,
    .serial_tx_out, .rts_n, .dtr_n, .infrared_transmit_out, .serial_memory_clock, .serial_memory_select,
    .serial_memory_data_out);
`default_nettype wire
